// >>> cfg_loader_pkg.sv
// shared constants for the configuration stream loader
package cfg_loader_pkg;

	// clock and power-on reset timing
	localparam int CLK_PERIOD_NS    = 8;
	localparam int POR_SHORT_MS     = 12;
	localparam int POR_LONG_MS      = 100;
	localparam int NS_PER_MS        = 1000000;
	localparam int POR_SHORT_CYCLES = POR_SHORT_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int POR_LONG_CYCLES  = POR_LONG_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int POR_CNT_W        = 24;

	// scheme select codes
	localparam logic [2:0] SCHEME_BYTE_PLAIN = 3'h0;
	localparam logic [2:0] SCHEME_BYTE_X4    = 3'h1;
	localparam logic [2:0] SCHEME_SERIAL_PS  = 3'h2;
	localparam logic [2:0] SCHEME_SERIAL_AS  = 3'h3;

	// byte-parallel x4 capture phase and last serial bit index
	localparam logic [1:0] X4_CAPTURE_PHASE = 2'h0;
	localparam logic [2:0] SERIAL_LAST_BIT  = 3'h7;

	// key and stream framing
	localparam int KEY_W          = 256;
	localparam int KEY_BYTES      = KEY_W / 8;
	localparam int KEY_IDX_W      = 5;
	localparam int CHECK_BYTES    = 4;
	localparam int CHECK_IDX_W    = 3;
	localparam logic [31:0] CHECK_WORD = 32'hC0DE5EED;

	// run-length escape: escape byte, then a byte whose low nibble is the zero run
	localparam logic [7:0] RUN_ESCAPE = 8'hA5;
	localparam logic [7:0] RUN_FILL   = 8'h00;
	localparam int         RUN_W      = 4;

	// loader states, gray along por -> reset -> config -> error
	typedef enum logic [1:0] {
		ST_POR    = 2'h0,
		ST_RESET  = 2'h1,
		ST_CONFIG = 2'h3,
		ST_ERROR  = 2'h2
	} loader_state_e;

endpackage

// >>> config_stream_decompress_decrypt.sv
// configuration stream front end: power-on reset, capture, decrypt, expand
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RULE1: expand compressed streams, never via boundary-scan
// RULE2: host holds each x4 byte four clocks
// RULE3: expansion outruns the link byte rate
// RULE4: per-device compression choice in serial chains
// RULE5: host gives all parallel-chain devices one setting
// RULE6: 256-bit key decrypts; wrong key fails
// RULE7: key from non-volatile or battery-backed store
// RULE8: serial decrypt keeps pace with bit rate
// RULE9: status held low until supplies good
// RULE10: brown-out when core and io supplies fail
// RULE11: delay select picks 12 ms or 100 ms
// RULE12: external low status extends reset
// RULE13: host holds request low on slow supplies
// RULE14: x4 mode captures every fourth rising edge
// RULE15: three link clocks of processing after capture
// RULE16: code 000 plain, 001 decrypt/decompress
// RULE17: reset stage while request or status low
// RULE18: words leave in stream order, none lost
module config_stream_decompress_decrypt #(
	parameter int POR_SHORT = cfg_loader_pkg::POR_SHORT_CYCLES,
	parameter int POR_LONG  = cfg_loader_pkg::POR_LONG_CYCLES
) (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	// supply monitors, high when above trip point, and reset delay select
	input  wire logic        core_supply_ok_i,
	input  wire logic        array_supply_ok_i,
	input  wire logic        io_supply_ok_i,
	input  wire logic        cfg_supply_ok_i,
	input  wire logic        predrv_supply_ok_i,
	input  wire logic        reset_delay_select_i,
	// configuration pins
	input  wire logic [2:0]  scheme_select_pins_i,
	input  wire logic        boundary_scan_cfg_i,
	input  wire logic        cfg_request_n_i,
	input  wire logic        status_n_i,
	output logic             status_n_o,
	output logic             status_n_oe_o,
	input  wire logic        cfg_link_clock_i,
	input  wire logic [7:0]  cfg_data_i,
	// per-device options
	input  wire logic        compress_en_i,
	input  wire logic        encrypt_en_i,
	input  wire logic        key_use_volatile_i,
	input  wire logic [255:0] key_nonvolatile_i,
	input  wire logic [255:0] key_volatile_i,
	// to configuration memory writer
	output logic             device_reset_o,
	output logic             cfg_busy_o,
	output logic             key_error_o,
	output logic [7:0]       cfg_word_o,
	output logic             cfg_word_valid_o
);

	// pin synchronisers: first stage feeds only the second
	logic [7:0] data_s1_reg, data_s2_reg;
	logic       clk_s1_reg, clk_s2_reg, clk_prev_reg;
	logic       req_s1_reg, req_s2_reg, stat_s1_reg, stat_s2_reg;
	logic [4:0] sup_s1_reg, sup_s2_reg;
	logic       sel_s1_reg, sel_s2_reg;
	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			data_s1_reg  <= 8'h00;
			data_s2_reg  <= 8'h00;
			clk_s1_reg   <= 1'b0;
			clk_s2_reg   <= 1'b0;
			clk_prev_reg <= 1'b0;
			req_s1_reg   <= 1'b0;
			req_s2_reg   <= 1'b0;
			stat_s1_reg  <= 1'b0;
			stat_s2_reg  <= 1'b0;
			sup_s1_reg   <= 5'h00;
			sup_s2_reg   <= 5'h00;
			sel_s1_reg   <= 1'b0;
			sel_s2_reg   <= 1'b0;
		end
		else
		begin
			data_s1_reg  <= cfg_data_i;
			data_s2_reg  <= data_s1_reg;
			clk_s1_reg   <= cfg_link_clock_i;
			clk_s2_reg   <= clk_s1_reg;
			clk_prev_reg <= clk_s2_reg;
			req_s1_reg   <= cfg_request_n_i;
			req_s2_reg   <= req_s1_reg;
			stat_s1_reg  <= status_n_i;
			stat_s2_reg  <= stat_s1_reg;
			sup_s1_reg   <= {core_supply_ok_i, array_supply_ok_i, io_supply_ok_i,
				cfg_supply_ok_i, predrv_supply_ok_i};
			sup_s2_reg   <= sup_s1_reg;
			sel_s1_reg   <= reset_delay_select_i;
			sel_s2_reg   <= sel_s1_reg;
		end
	end

	// decoded conditions
	logic link_rise, all_ok, brown_out, hold_reset, is_x4, is_serial;
	logic use_decrypt, use_expand;
	logic [255:0] key_sel;
	assign link_rise  = clk_s2_reg & ~clk_prev_reg;
	assign all_ok     = &sup_s2_reg;                                       // see RULE9
	// core or array low together with io, cfg or predriver low
	assign brown_out  = ~(sup_s2_reg[4] & sup_s2_reg[3]) & ~(&sup_s2_reg[2:0]); // see RULE10
	assign hold_reset = ~req_s2_reg | ~stat_s2_reg;                        // see RULE12 RULE13 RULE17
	assign is_x4      = scheme_select_pins_i == cfg_loader_pkg::SCHEME_BYTE_X4;   // see RULE16
	assign is_serial  = scheme_select_pins_i == cfg_loader_pkg::SCHEME_SERIAL_PS
		|| scheme_select_pins_i == cfg_loader_pkg::SCHEME_SERIAL_AS;
	// plain byte mode (000) bypasses both; boundary-scan never expands
	assign use_decrypt = encrypt_en_i & ~boundary_scan_cfg_i & (is_x4 | is_serial);
	assign use_expand  = compress_en_i & ~boundary_scan_cfg_i & (is_x4 | is_serial); // see RULE1 RULE4
	assign key_sel     = key_use_volatile_i ? key_volatile_i : key_nonvolatile_i; // see RULE7

	// loader state and datapath registers
	cfg_loader_pkg::loader_state_e state_reg, state_next;
	logic [cfg_loader_pkg::POR_CNT_W-1:0] por_cnt_reg, por_cnt_next, por_target;
	logic [1:0]  phase_reg, phase_next;
	logic [2:0]  bit_reg, bit_next;
	logic [7:0]  shift_reg, shift_next;
	logic [cfg_loader_pkg::KEY_IDX_W-1:0]   kidx_reg, kidx_next;
	logic [cfg_loader_pkg::CHECK_IDX_W-1:0] chk_reg, chk_next;
	logic        esc_reg, esc_next;
	logic [cfg_loader_pkg::RUN_W-1:0] run_reg, run_next;
	logic [7:0]  word_reg, word_next;
	logic        wvalid_reg, wvalid_next;

	// byte picked from the key by stream position
	function automatic logic [7:0] key_byte(input logic [255:0] k,
		input logic [cfg_loader_pkg::KEY_IDX_W-1:0] idx);
		key_byte = k[idx * 8 +: 8];
	endfunction

	assign por_target = sel_s2_reg ? cfg_loader_pkg::POR_CNT_W'(POR_SHORT)
		: cfg_loader_pkg::POR_CNT_W'(POR_LONG);                       // see RULE11

	// next-state logic for the whole loader
	logic       raw_valid;
	logic [7:0] raw_byte, plain;
	always_comb
	begin
		state_next  = state_reg;
		por_cnt_next = por_cnt_reg;
		phase_next  = phase_reg;
		bit_next    = bit_reg;
		shift_next  = shift_reg;
		kidx_next   = kidx_reg;
		chk_next    = chk_reg;
		esc_next    = esc_reg;
		run_next    = run_reg;
		word_next   = word_reg;
		wvalid_next = 1'b0;
		raw_valid   = 1'b0;
		raw_byte    = data_s2_reg;
		plain       = 8'h00;
		case (state_reg)
			cfg_loader_pkg::ST_POR:
			begin
				// count only while every supply is good
				if (!all_ok)
					por_cnt_next = '0;                                  // see RULE9
				else if (por_cnt_reg >= por_target)
					state_next = cfg_loader_pkg::ST_RESET;
				else
					por_cnt_next = por_cnt_reg + 1'b1;
			end
			cfg_loader_pkg::ST_RESET:
			begin
				phase_next = cfg_loader_pkg::X4_CAPTURE_PHASE;
				bit_next   = 3'h0;
				kidx_next  = '0;
				chk_next   = '0;
				esc_next   = 1'b0;
				run_next   = '0;
				if (!hold_reset)
					state_next = cfg_loader_pkg::ST_CONFIG;              // see RULE17
			end
			cfg_loader_pkg::ST_CONFIG:
			begin
				if (hold_reset)
					state_next = cfg_loader_pkg::ST_RESET;               // see RULE12
				// capture: serial shifts lsb first, x4 on phase 0 only
				if (link_rise && is_serial)
				begin
					shift_next = {data_s2_reg[0], shift_reg[7:1]};
					bit_next   = bit_reg + 1'b1;
					raw_byte   = {data_s2_reg[0], shift_reg[7:1]};
					raw_valid  = bit_reg == cfg_loader_pkg::SERIAL_LAST_BIT; // see RULE8
				end
				else if (link_rise && is_x4)
				begin
					phase_next = phase_reg + 1'b1;                      // see RULE15
					raw_valid  = phase_reg == cfg_loader_pkg::X4_CAPTURE_PHASE; // see RULE2 RULE14
				end
				else if (link_rise)
					raw_valid = 1'b1;
				// pending zero run drains one byte per clock
				if (run_reg != '0)
				begin
					run_next    = run_reg - 1'b1;
					word_next   = cfg_loader_pkg::RUN_FILL;
					wvalid_next = 1'b1;                                  // see RULE3
				end
				else if (raw_valid)
				begin
					plain = use_decrypt ? raw_byte ^ key_byte(key_sel, kidx_reg) : raw_byte; // see RULE6
					kidx_next = kidx_reg + 1'b1;
					if (use_decrypt && chk_reg < cfg_loader_pkg::CHECK_IDX_W'(cfg_loader_pkg::CHECK_BYTES))
					begin
						// leading check bytes prove the key matches
						chk_next = chk_reg + 1'b1;
						if (plain != cfg_loader_pkg::CHECK_WORD[chk_reg[1:0] * 8 +: 8])
							state_next = cfg_loader_pkg::ST_ERROR;           // see RULE6
					end
					else if (use_expand && esc_reg)
					begin
						esc_next = 1'b0;
						run_next = plain[cfg_loader_pkg::RUN_W-1:0];     // see RULE1
					end
					else if (use_expand && plain == cfg_loader_pkg::RUN_ESCAPE)
						esc_next = 1'b1;
					else
					begin
						word_next   = plain;
						wvalid_next = 1'b1;                              // see RULE18
					end
				end
			end
			cfg_loader_pkg::ST_ERROR:
			begin
				// stays here until the host restarts with the request line
				if (!req_s2_reg)
					state_next = cfg_loader_pkg::ST_RESET;
			end
			default:
				state_next = cfg_loader_pkg::ST_POR;
		endcase
		// brown-out (core side and io side both low) overrides everything
		if (state_reg != cfg_loader_pkg::ST_POR && brown_out)
		begin
			state_next   = cfg_loader_pkg::ST_POR;                       // see RULE10
			por_cnt_next = '0;
		end
	end

	// register the loader state
	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			state_reg   <= cfg_loader_pkg::ST_POR;
			por_cnt_reg <= '0;
			phase_reg   <= cfg_loader_pkg::X4_CAPTURE_PHASE;
			bit_reg     <= 3'h0;
			shift_reg   <= 8'h00;
			kidx_reg    <= '0;
			chk_reg     <= '0;
			esc_reg     <= 1'b0;
			run_reg     <= '0;
			word_reg    <= 8'h00;
			wvalid_reg  <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			por_cnt_reg <= por_cnt_next;
			phase_reg   <= phase_next;
			bit_reg     <= bit_next;
			shift_reg   <= shift_next;
			kidx_reg    <= kidx_next;
			chk_reg     <= chk_next;
			esc_reg     <= esc_next;
			run_reg     <= run_next;
			word_reg    <= word_next;
			wvalid_reg  <= wvalid_next;
		end
	end

	// open-drain status: only ever pulls low
	assign status_n_o       = 1'b0;
	assign status_n_oe_o    = state_reg == cfg_loader_pkg::ST_POR
		|| state_reg == cfg_loader_pkg::ST_ERROR;                      // see RULE9
	assign device_reset_o   = state_reg != cfg_loader_pkg::ST_CONFIG;
	assign cfg_busy_o       = is_x4 && phase_reg != cfg_loader_pkg::X4_CAPTURE_PHASE; // see RULE15
	assign key_error_o      = state_reg == cfg_loader_pkg::ST_ERROR;
	assign cfg_word_o       = word_reg;
	assign cfg_word_valid_o = wvalid_reg;

endmodule

`default_nettype wire

// >>> cfg_loader_assertions.sv
// port-level checks for the configuration stream loader
`timescale 1ns/100ps
`default_nettype none
module cfg_loader_assertions (
	// watched ports
	input wire logic       mclk_i,
	input wire logic       rstn_i,
	input wire logic       core_supply_ok_i,
	input wire logic       io_supply_ok_i,
	input wire logic [2:0] scheme_select_pins_i,
	input wire logic       cfg_request_n_i,
	input wire logic       status_n_i,
	input wire logic       status_n_o,
	input wire logic       status_n_oe_o,
	input wire logic       cfg_link_clock_i,
	input wire logic       device_reset_o,
	input wire logic       cfg_busy_o,
	input wire logic       key_error_o,
	input wire logic       cfg_word_valid_o
);
	// single domain, so one clock and one reset for all
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	a_status_data_low: assert property (status_n_o == 1'b0)
		else $error("status pin data not low");
	a_pull_means_reset: assert property (status_n_oe_o |-> device_reset_o)
		else $error("status pulled while device out of reset");
	// five cycles cover the two sync flops plus the state register
	a_request_holds_rst: assert property (!cfg_request_n_i [*5] |-> device_reset_o)
		else $error("request low but device not in reset");
	a_status_holds_rst: assert property (!status_n_i [*5] |-> device_reset_o)
		else $error("status low but device not in reset");
	a_brownout_pulls: assert property ((!core_supply_ok_i && !io_supply_ok_i) [*5]
		|-> status_n_oe_o)
		else $error("brown-out did not pull status");
	a_error_pulls_status: assert property (key_error_o |-> status_n_oe_o && device_reset_o)
		else $error("key error without status pull");
	a_busy_only_x4: assert property (cfg_busy_o
		|-> scheme_select_pins_i == cfg_loader_pkg::SCHEME_BYTE_X4)
		else $error("busy outside x4 mode");
	a_word_in_config: assert property (cfg_word_valid_o |-> !$past(device_reset_o))
		else $error("word delivered outside config");
	a_word_after_edge: assert property ($rose(cfg_word_valid_o) |-> $past(cfg_link_clock_i, 3))
		else $error("word without a link clock rise");

	c_word: cover property (cfg_word_valid_o);
	c_key_error: cover property (key_error_o);
	c_busy: cover property (cfg_busy_o);
endmodule
bind config_stream_decompress_decrypt cfg_loader_assertions u_chk (.mclk_i, .rstn_i,
	.core_supply_ok_i, .io_supply_ok_i, .scheme_select_pins_i, .cfg_request_n_i, .status_n_i,
	.status_n_o, .status_n_oe_o, .cfg_link_clock_i, .device_reset_o, .cfg_busy_o,
	.key_error_o, .cfg_word_valid_o);
`default_nettype wire

// >>> cfg_host_model.sv
// behavioural configuration host driving link clock and data
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model (
	// link pins
	output logic       link_clk_o,
	output logic [7:0] data_o
);
	initial
	begin
		link_clk_o = 1'b0;
		data_o     = 8'h00;
	end
	// clock stands low between bytes; data shows the inverse once released
	task automatic send(input logic [7:0] b, input int edges, input bit serial);
		for (int i = 0; i < (serial ? 8 : 1); i++)
		begin
			data_o = serial ? {8{b[i]}} : b;
			repeat (edges)
			begin
				#80 link_clk_o = 1'b1;
				#80 link_clk_o = 1'b0;
			end
		end
		data_o = ~b;
		// one idle mclk so a back-to-back send never reassigns data in the same step
		#8;
	endtask
endmodule
`default_nettype wire

// >>> config_stream_decompress_decrypt_tb.sv
// self-checking bench for the configuration stream loader
`timescale 1ns/100ps
`default_nettype none
module config_stream_decompress_decrypt_tb;
	logic mclk_i = 0, rstn_i = 0, sup = 1, core_ok = 1, io_ok = 1, dsel = 1, bscan = 0;
	logic [2:0] sch = 3'h0;
	logic req_n = 0, hold_n = 1, comp = 0, enc = 0, kvol = 0;
	logic [255:0] knv = {32{8'h3C}}, kv = {32{8'h5A}};
	logic st_o, st_oe, lclk, rst_o, busy, kerr, vld, saw_busy = 0;
	logic [7:0] data, word, got[$], exp[$];
	logic [15:0] rows[4] = '{16'h1212, 16'hA5A5, 16'h0303, 16'hFEFE};
	int num_errors = 0, tests_run = 0, cyc = 0;
	wire status_n = hold_n & ~st_oe; // pull-up unless someone pulls low

	always #4 mclk_i = ~mclk_i;
	cfg_host_model host (.link_clk_o(lclk), .data_o(data));
	config_stream_decompress_decrypt #(.POR_SHORT(20), .POR_LONG(50)) dut (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .core_supply_ok_i(core_ok),
		.array_supply_ok_i(sup), .io_supply_ok_i(io_ok), .cfg_supply_ok_i(sup),
		.predrv_supply_ok_i(sup), .reset_delay_select_i(dsel), .scheme_select_pins_i(sch),
		.boundary_scan_cfg_i(bscan), .cfg_request_n_i(req_n), .status_n_i(status_n),
		.status_n_o(st_o), .status_n_oe_o(st_oe), .cfg_link_clock_i(lclk), .cfg_data_i(data),
		.compress_en_i(comp), .encrypt_en_i(enc), .key_use_volatile_i(kvol),
		.key_nonvolatile_i(knv), .key_volatile_i(kv), .device_reset_o(rst_o),
		.cfg_busy_o(busy), .key_error_o(kerr), .cfg_word_o(word), .cfg_word_valid_o(vld));

	// collect delivered words; the ceiling cuts a hang short
	always @(posedge mclk_i)
	begin
		if (vld === 1'b1) got.push_back(word);
		if (busy === 1'b1) saw_busy <= 1'b1;
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		tests_run++;
		if (seen !== want)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	// drop the request, set options, raise it and wait for config
	task automatic restart(input logic [2:0] s, input logic c, e, v, b);
		req_n = 0;
		tick(8);
		{sch, comp, enc, kvol, bscan} = {s, c, e, v, b};
		req_n = 1;
		for (int i = 0; i < 100 && rst_o !== 1'b0; i++) tick(1);
		check({7'h0, rst_o}, 8'h00);
	endtask
	// every delivered word, in order, against the expectation
	task automatic drain();
		tick(10);
		check(8'(got.size()), 8'(exp.size()));
		foreach (exp[i]) check(i < got.size() ? got[i] : 8'hXX, exp[i]);
		got.delete();
		exp.delete();
	endtask
	// check word then one payload byte, each xored with the key byte
	task automatic secure(input logic [7:0] k, input int edges, input bit ser);
		logic [7:0] chk[5] = '{8'hED, 8'h5E, 8'hDE, 8'hC0, 8'h42};
		foreach (chk[i]) host.send(chk[i] ^ k, edges, ser);
		// payload only appears when the stream key equals the selected key
		if (k == (kvol ? 8'h5A : 8'h3C)) exp.push_back(8'h42);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		tick(6);
		check({5'h0, st_o, st_oe, rst_o}, 8'h03);
		rstn_i = 1;
		// request kept low until the supplies are known good
		tick(40);
		check({7'h0, rst_o}, 8'h01);
		hold_n = 0;
		req_n = 1;
		tick(30);
		check({7'h0, rst_o}, 8'h01);
		hold_n = 1;
		restart(3'h0, 1, 0, 0, 0);
		foreach (rows[i])
		begin
			host.send(rows[i][15:8], 1, 0);
			exp.push_back(rows[i][7:0]);
		end
		drain();
		restart(3'h1, 1, 0, 0, 0);
		foreach (rows[i]) host.send(i == 0 ? 8'hA5 : 8'h77, 4, 0);
		exp = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h77, 8'h77};
		drain();
		check({7'h0, saw_busy}, 8'h01);
		restart(3'h2, 1, 0, 0, 0);
		host.send(8'hA5, 1, 1);
		host.send(8'h02, 1, 1);
		exp = '{8'h00, 8'h00};
		drain();
		restart(3'h1, 1, 0, 0, 1);
		host.send(8'hA5, 4, 0);
		exp = '{8'hA5};
		drain();
		restart(3'h1, 0, 1, 0, 0);
		secure(8'h3C, 4, 0);
		drain();
		restart(3'h3, 0, 1, 1, 0);
		secure(8'h5A, 1, 1);
		drain();
		restart(3'h2, 0, 1, 1, 0);
		secure(8'h3C, 1, 1);
		check({6'h0, kerr, st_oe}, 8'h03);
		drain();
		// leave the error state first so the brown-out check sees a real change
		restart(3'h0, 0, 0, 0, 0);
		{core_ok, io_ok, dsel} = 3'b000;
		tick(6);
		check({6'h0, st_oe, rst_o}, 8'h03);
		{core_ok, io_ok} = 2'b11;
		tick(35);
		check({7'h0, st_oe}, 8'h01);
		tick(40);
		check({7'h0, st_oe}, 8'h00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
